// file: irmc_map.svh
// irmc_map.svh: offsets-free constants for the mode and reset controller
// assumes inclusion by bare name from the controller module
`ifndef IRMC_MAP_SVH
`define IRMC_MAP_SVH
// ----------------------------------------
// mode field codes
// ----------------------------------------
`define IRMC_MODE_STBY 3'h0
`define IRMC_MODE_NVM 3'h1
`define IRMC_MODE_SINGLE 3'h2
`define IRMC_MODE_CONT0 3'h4
`define IRMC_NVM_KEY 8'ha5
// ----------------------------------------
// target addresses
// ----------------------------------------
`define IRMC_ADDR_LL 7'h64
`define IRMC_ADDR_LH 7'h65
`define IRMC_ADDR_HL 7'h66
// ----------------------------------------
// timing: base measurement time per filter step, in us
// ----------------------------------------
`define IRMC_MEAS_BASE_US 1000
`define IRMC_CLK_MHZ 10
`define IRMC_MEAS_BASE_CYC ((`IRMC_MEAS_BASE_US) * (`IRMC_CLK_MHZ))
// ----------------------------------------
// reset values
// ----------------------------------------
`define IRMC_THR_RST 16'h0000
`endif

// file: irmc_pkg.sv
// irmc_pkg.sv: types for the mode and reset controller
// assumes irmc_map.svh is on the include path
package irmc_pkg;
    typedef enum logic [2:0] {
        IRMC_ST_STBY = 3'b000,
        IRMC_ST_MEAS = 3'b001,
        IRMC_ST_WAIT = 3'b010,
        IRMC_ST_HOLD = 3'b011,
        IRMC_ST_NVM = 3'b100
    } irmc_state_t;
endpackage : irmc_pkg

// file: irmc_sync.sv
// irmc_sync.sv: two-flop synchroniser for pin inputs
// assumes one clock, synchronous active-low reset
`timescale 1ns/10ps
module irmc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // data
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    // refuse an empty synchroniser
    if (WIDTH < 1) begin : g_bad_width
        $error("irmc_sync: WIDTH must be at least 1");
    end
    logic [WIDTH-1:0] meta_r;
    // first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_r <= '0;
            syncOut <= '0;
        end else begin
            meta_r <= asyncIn;
            syncOut <= meta_r;
        end
    end
endmodule : irmc_sync

// file: irmc_ctrl.sv
// irmc_ctrl.sv: mode, reset and switch-mode comparator of the IR presence sensor
// assumes pins arrive asynchronous; register writes come from same-clock logic
// Function
// (RULE1) power-up with powerdown pin high resets all and enters standby
// (RULE2) powerdown pin low holds everything in reset, no function
// (RULE3) powerdown pin low at power-up: power-on reset does not fire
// (RULE4) writing soft reset bit resets every register
// (RULE5) io supply monitor falling low resets the device
// (RULE6) every reset source returns registers to initial values
// (RULE7) straps choose address 64h/65h/66h or switch mode with bus off
// (RULE8) switch mode: interrupt active when a channel difference leaves threshold range
// (RULE9) switch-mode comparison uses stored hysteresis to avoid chatter
// (RULE10) in switch mode host keeps bus lines high and never accesses
// (RULE11) mode codes: standby 000, single 010, continuous 100-111, nvm 001 plus enable
// (RULE12) continuous 1..3 measure:wait 1:1,1:3,1:7, periods x8,x16,x32
// (RULE13) host passes through standby between any two other modes
// (RULE14) standby powers off all but power-on reset, registers stay accessible
// (RULE15) written values survive standby, cleared only by reset
// (RULE16) host avoids status and data registers during standby
// (RULE17) nvm access only in nvm mode, refused in standby
// (RULE18) nvm writes allowed only after key field holds a5h
// (RULE19) no measurement during nvm access mode
// (RULE20) single shot measures once, stores results, powers analog down
// (RULE21) after status reads in single shot, return to standby alone
// (RULE22) filter cutoff field sets single measurement length
// (RULE23) mode rewrite mid-measurement aborts and keeps previous results
// (RULE24) continuous 0 repeats back to back, storing each result
// (RULE25) undefined mode codes leave the device in standby
`timescale 1ns/10ps
`include "irmc_map.svh"
module irmc_ctrl
    import irmc_pkg::*;
#(
    parameter int MEAS_BASE_CYC = `IRMC_MEAS_BASE_CYC,
    parameter int DW = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // pins
    input wire logic powerdown_pin,
    input wire logic addr_strap_0,
    input wire logic addr_strap_1,
    input wire logic supplyOk,
    input wire logic ioSupplyLow,
    // register side, same clock
    input wire logic modeWrite,
    input wire logic [2:0] op_mode_select,
    input wire logic nvm_mode_enable,
    input wire logic keyWrite,
    input wire logic [7:0] nvm_write_key,
    input wire logic soft_reset_bit,
    input wire logic [2:0] filter_cutoff_select,
    input wire logic statusSecondRead,
    input wire logic nvmReq,
    input wire logic nvmWe,
    // measurement results
    input wire logic signed [DW-1:0] ir_channel_1,
    input wire logic signed [DW-1:0] ir_channel_2,
    input wire logic signed [DW-1:0] ir_channel_3,
    input wire logic signed [DW-1:0] ir_channel_4,
    // stored thresholds
    input wire logic signed [DW-1:0] thrUpper,
    input wire logic signed [DW-1:0] thrLower,
    input wire logic [DW-1:0] thrHyst,
    // status and control outputs
    output logic regReset,
    output logic [2:0] modeState,
    output logic analogOn,
    output logic measStart,
    output logic resultStore,
    output logic nvmGrant,
    output logic nvmWriteGrant,
    output logic switchMode,
    output logic busEnable,
    output logic [6:0] targetAddr,
    output logic intOut
);
    // refuse parameters the counters and comparator cannot serve
    if (MEAS_BASE_CYC < 1 || DW < 2) begin : g_bad_params
        $error("irmc_ctrl: bad parameters");
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [4:0] pinSync;
    irmc_sync #(.WIDTH(5)) uSync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .asyncIn({ioSupplyLow, supplyOk, addr_strap_1, addr_strap_0, powerdown_pin}),
        .syncOut(pinSync)
    );
    logic pdnHigh, strap0, strap1, supOk, ioLow;
    assign {ioLow, supOk, strap1, strap0, pdnHigh} = pinSync;

    // ----------------------------------------
    // reset gathering
    // ----------------------------------------
    logic supOkPrev_r;
    logic porFire;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) supOkPrev_r <= 1'b0;
        else supOkPrev_r <= supOk;
    end
    // power-on pulse only counts while the pin is high
    assign porFire = supOk & ~supOkPrev_r & pdnHigh; // see RULE1 see RULE3
    // any source forces registers back to initial values
    assign regReset = ~rst_n | ~pdnHigh | porFire | soft_reset_bit | ioLow
        | ~supOk; // see RULE2 see RULE4 see RULE5 see RULE6

    // ----------------------------------------
    // strap decode, captured while in reset
    // ----------------------------------------
    logic [1:0] straps_r;
    // straps only load while in reset, so a later pin change is ignored
    always_ff @(posedge sys_clk) begin
        if (regReset) straps_r <= {strap1, strap0};
    end
    always_comb begin
        unique case (straps_r) // see RULE7
            2'b00: targetAddr = `IRMC_ADDR_LL;
            2'b01: targetAddr = `IRMC_ADDR_LH;
            2'b10: targetAddr = `IRMC_ADDR_HL;
            2'b11: targetAddr = 7'h00;
        endcase
    end
    assign switchMode = &straps_r;
    assign busEnable = ~switchMode & pdnHigh; // see RULE7 see RULE10

    // ----------------------------------------
    // mode register and nvm key
    // ----------------------------------------
    logic [2:0] mode_r;
    logic key_r;
    irmc_state_t state_r, state_nxt;
    always_ff @(posedge sys_clk) begin
        if (regReset) begin
            mode_r <= `IRMC_MODE_STBY;
        end else if (modeWrite) begin
            // undefined codes or nvm without enable stay in standby
            if (op_mode_select == 3'h3 ||
                (op_mode_select == `IRMC_MODE_NVM && !nvm_mode_enable))
                mode_r <= `IRMC_MODE_STBY; // see RULE25
            else
                mode_r <= op_mode_select; // see RULE11 see RULE15
        end else if (state_r == IRMC_ST_HOLD && statusSecondRead) begin
            mode_r <= `IRMC_MODE_STBY; // see RULE21
        end
    end
    // key is forgotten on leaving nvm mode, so each visit needs a fresh key
    always_ff @(posedge sys_clk) begin
        if (regReset || mode_r != `IRMC_MODE_NVM) key_r <= 1'b0;
        else if (keyWrite) key_r <= (nvm_write_key == `IRMC_NVM_KEY);
    end

    // ----------------------------------------
    // measurement length from filter select and mode
    // ----------------------------------------
    // one measurement: base length scaled by the filter select
    function automatic logic [31:0] measLen(input logic [2:0] md, input logic [2:0] fc);
        logic [31:0] b;
        b = 32'(MEAS_BASE_CYC) << fc; // see RULE22
        // intermittent modes measure four lengths, so periods come out x8, x16, x32
        measLen = (md[2] && md[1:0] != 2'b00) ? (b << 2) : b; // see RULE12
    endfunction : measLen
    // wait phase is one, three or seven measurement lengths
    function automatic logic [31:0] waitLen(input logic [2:0] md, input logic [2:0] fc);
        logic [31:0] m;
        m = measLen(md, fc);
        unique case (md[1:0]) // see RULE12
            2'b01: waitLen = m;
            2'b10: waitLen = 32'(3) * m;
            2'b11: waitLen = 32'(7) * m;
            default: waitLen = 32'h0;
        endcase
    endfunction : waitLen

    // ----------------------------------------
    // normal-mode state machine
    // ----------------------------------------
    logic [31:0] cnt_r;
    logic modeChange;
    assign modeChange = modeWrite;
    // switch mode keeps measuring back to back, normal modes follow mode_r
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            IRMC_ST_STBY: begin
                if (mode_r == `IRMC_MODE_NVM) state_nxt = IRMC_ST_NVM;
                else if (mode_r[2] || mode_r == `IRMC_MODE_SINGLE) state_nxt = IRMC_ST_MEAS;
            end
            IRMC_ST_MEAS: begin
                if (modeChange) state_nxt = IRMC_ST_STBY; // see RULE23
                else if (cnt_r == 32'h1) begin
                    if (mode_r == `IRMC_MODE_SINGLE) state_nxt = IRMC_ST_HOLD; // see RULE20
                    else if (mode_r[1:0] == 2'b00) state_nxt = IRMC_ST_MEAS; // see RULE24
                    else state_nxt = IRMC_ST_WAIT;
                end
            end
            IRMC_ST_WAIT: begin
                if (modeChange) state_nxt = IRMC_ST_STBY;
                else if (cnt_r == 32'h1) state_nxt = IRMC_ST_MEAS;
            end
            IRMC_ST_HOLD: begin
                if (modeChange || mode_r != `IRMC_MODE_SINGLE) state_nxt = IRMC_ST_STBY;
            end
            IRMC_ST_NVM: begin
                if (mode_r != `IRMC_MODE_NVM) state_nxt = IRMC_ST_STBY;
            end
            default: state_nxt = IRMC_ST_STBY;
        endcase
        if (switchMode && state_nxt != IRMC_ST_MEAS) state_nxt = IRMC_ST_MEAS;
    end
    always_ff @(posedge sys_clk) begin
        if (regReset) state_r <= IRMC_ST_STBY;
        else state_r <= state_nxt;
    end
    // cycle counter for measure and wait phases
    always_ff @(posedge sys_clk) begin
        if (regReset) cnt_r <= 32'h0;
        else if (state_nxt == IRMC_ST_MEAS && (state_r != IRMC_ST_MEAS || cnt_r == 32'h1))
            cnt_r <= measLen(mode_r, filter_cutoff_select);
        else if (state_nxt == IRMC_ST_WAIT && state_r != IRMC_ST_WAIT)
            cnt_r <= waitLen(mode_r, filter_cutoff_select);
        else if (cnt_r != 32'h0) cnt_r <= cnt_r - 32'h1;
    end
    assign measStart = (state_nxt == IRMC_ST_MEAS) &&
        (state_r != IRMC_ST_MEAS || cnt_r == 32'h1);
    // results stored only on completion, so an abort keeps old data
    assign resultStore = state_r == IRMC_ST_MEAS && cnt_r == 32'h1 && !modeChange; // see RULE23
    // analog runs only while measuring; standby keeps only power-on logic
    assign analogOn = state_r == IRMC_ST_MEAS; // see RULE14 see RULE19
    assign modeState = mode_r;
    // the stored mode gates too, so a standby write refuses access at once
    assign nvmGrant = state_r == IRMC_ST_NVM && mode_r == `IRMC_MODE_NVM && nvmReq; // see RULE17
    assign nvmWriteGrant = nvmGrant && nvmWe && key_r; // see RULE18

    // ----------------------------------------
    // switch-mode comparator with hysteresis
    // ----------------------------------------
    // one extra bit keeps the channel differences from wrapping
    logic signed [DW:0] diffA, diffB, up, lo, upRel, loRel;
    always_comb begin
        diffA = (DW+1)'(ir_channel_1) - (DW+1)'(ir_channel_3);
        diffB = (DW+1)'(ir_channel_2) - (DW+1)'(ir_channel_4);
        up = (DW+1)'(thrUpper);
        lo = (DW+1)'(thrLower);
        upRel = up - (DW+1)'({1'b0, thrHyst});
        loRel = lo + (DW+1)'({1'b0, thrHyst});
    end
    always_ff @(posedge sys_clk) begin
        if (regReset || !switchMode) intOut <= 1'b0;
        else if (resultStore) begin
            if (diffA > up || diffA < lo || diffB > up || diffB < lo)
                intOut <= 1'b1; // see RULE8
            else if (diffA <= upRel && diffA >= loRel && diffB <= upRel && diffB >= loRel)
                intOut <= 1'b0; // see RULE9
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_pdn_resets: assert property (@(posedge sys_clk) !pdnHigh |-> regReset) // see RULE2
        else $error("powerdown low without reset");
    a_nvm_key_gate: assert property (@(posedge sys_clk) disable iff (!rst_n) // see RULE18
        nvmWriteGrant |-> key_r && state_r == IRMC_ST_NVM)
        else $error("nvm write without key");
    a_nvm_no_meas: assert property (@(posedge sys_clk) disable iff (regReset) // see RULE19
        mode_r == `IRMC_MODE_NVM && !switchMode |-> !analogOn && !measStart)
        else $error("measurement in nvm mode");
    a_stby_no_nvm: assert property (@(posedge sys_clk) disable iff (regReset) // see RULE17
        mode_r == `IRMC_MODE_STBY |-> !nvmGrant && !nvmWriteGrant)
        else $error("nvm access in standby");
    a_reset_stby: assert property (@(posedge sys_clk) // see RULE6
        regReset |=> mode_r == `IRMC_MODE_STBY && state_r == IRMC_ST_STBY)
        else $error("reset did not give standby");
    a_bad_mode_stby: assert property (@(posedge sys_clk) disable iff (regReset) // see RULE25
        modeWrite && op_mode_select == 3'h3 |=> mode_r == `IRMC_MODE_STBY)
        else $error("undefined mode not standby");
    a_single_return: assert property (@(posedge sys_clk) disable iff (regReset) // see RULE21
        state_r == IRMC_ST_HOLD && statusSecondRead && !modeWrite
        |=> mode_r == `IRMC_MODE_STBY ##1 state_r == IRMC_ST_STBY)
        else $error("single shot did not return");
    a_abort_no_store: assert property (@(posedge sys_clk) disable iff (regReset) // see RULE23
        state_r == IRMC_ST_MEAS && modeChange |-> !resultStore)
        else $error("aborted result stored");
    a_switch_bus_off: assert property (@(posedge sys_clk) disable iff (regReset) // see RULE7
        switchMode |-> !busEnable)
        else $error("bus enabled in switch mode");
    a_int_set: assert property (@(posedge sys_clk) disable iff (regReset) // see RULE8
        switchMode && resultStore && (diffA > up || diffA < lo || diffB > up || diffB < lo)
        |=> intOut)
        else $error("interrupt not raised");
    a_int_hold: assert property (@(posedge sys_clk) disable iff (regReset) // see RULE9
        switchMode && !resultStore |=> $stable(intOut))
        else $error("interrupt moved without a result");
    a_normal_no_int: assert property (@(posedge sys_clk) disable iff (regReset) // see RULE8
        !switchMode |-> !intOut)
        else $error("interrupt active in normal mode");
    a_stby_dark: assert property (@(posedge sys_clk) disable iff (regReset) // see RULE14
        mode_r == `IRMC_MODE_STBY && !switchMode |-> !analogOn)
        else $error("analog on in standby");
endmodule : irmc_ctrl

// file: irmc_host_model.sv
// irmc_host_model.sv: host side model for the mode and reset controller
// assumes the bench clock; every write is driven 1 ns after a rising edge
`timescale 1ns/10ps
module irmc_host_model (
    // clock and bus state
    input wire logic sys_clk,
    input wire logic busOff,
    // register writes
    output logic modeWrite,
    output logic [2:0] op_mode_select,
    output logic nvm_mode_enable,
    output logic keyWrite,
    output logic [7:0] nvm_write_key,
    output logic statusSecondRead
);
    logic [2:0] curMode;
    // idle values at time zero
    initial begin
        {modeWrite, keyWrite, statusSecondRead, nvm_mode_enable} = 4'h0;
        op_mode_select = 3'h0;
        nvm_write_key = 8'h00;
        curMode = 3'h0;
    end
    // one strobe edge, data scrambled once released
    task automatic pulse_mode(input logic [2:0] code, input logic en);
        @(posedge sys_clk);
        #1 {op_mode_select, nvm_mode_enable, modeWrite} = {code, en, 1'b1};
        @(posedge sys_clk);
        #1 {op_mode_select, nvm_mode_enable, modeWrite} = {~code, ~en, 1'b0};
    endtask : pulse_mode
    // mode change, routed through standby, silent when the bus is off
    task automatic set_mode(input logic [2:0] code, input logic en);
        if (busOff !== 1'b1) begin
            if (curMode != 3'h0 && code != 3'h0) pulse_mode(3'h0, 1'b0);
            pulse_mode(code, en);
            curMode = code;
        end
    endtask : set_mode
    // write key field
    task automatic write_key(input logic [7:0] k);
        @(posedge sys_clk);
        #1 {nvm_write_key, keyWrite} = {k, 1'b1};
        @(posedge sys_clk);
        #1 {nvm_write_key, keyWrite} = {~k, 1'b0};
    endtask : write_key
    // end of a status read, pulsed for one cycle without waiting for a stored result
    task automatic status_done();
        @(posedge sys_clk);
        #1 statusSecondRead = 1'b1;
        @(posedge sys_clk);
        #1 statusSecondRead = 1'b0;
    endtask : status_done
endmodule : irmc_host_model

// file: irmc_ctrl_tb.sv
// irmc_ctrl_tb.sv: self-checking bench for the mode and reset controller
// assumes irmc_ctrl with a short measurement base and the host model
`timescale 1ns/10ps
module irmc_ctrl_tb;
    import irmc_pkg::*;
    localparam int MB = 4;
    logic sys_clk, rst_n, powerdown_pin, addr_strap_0, addr_strap_1, supplyOk, ioSupplyLow;
    logic modeWrite, nvm_mode_enable, keyWrite, soft_reset_bit, statusSecondRead, nvmReq, nvmWe;
    logic [2:0] op_mode_select, filter_cutoff_select, modeState;
    logic [7:0] nvm_write_key;
    logic signed [15:0] ch1, ch2, ch3, ch4, thrUpper, thrLower;
    logic [15:0] thrHyst;
    logic regReset, analogOn, measStart, resultStore, nvmGrant, nvmWriteGrant;
    logic switchMode, busEnable, intOut, expInt;
    logic [6:0] targetAddr;
    int bad_count, n_compared, n, fc, s, d1, d2;
    irmc_ctrl #(.MEAS_BASE_CYC(MB), .DW(16)) irmc_ctrl_i (.sys_clk, .rst_n, .powerdown_pin,
        .addr_strap_0, .addr_strap_1, .supplyOk, .ioSupplyLow, .modeWrite, .op_mode_select,
        .nvm_mode_enable, .keyWrite, .nvm_write_key, .soft_reset_bit, .filter_cutoff_select,
        .statusSecondRead, .nvmReq, .nvmWe, .ir_channel_1(ch1), .ir_channel_2(ch2),
        .ir_channel_3(ch3), .ir_channel_4(ch4), .thrUpper, .thrLower, .thrHyst, .regReset,
        .modeState, .analogOn, .measStart, .resultStore, .nvmGrant, .nvmWriteGrant,
        .switchMode, .busEnable, .targetAddr, .intOut);
    irmc_host_model irmc_host_model_i (.sys_clk, .busOff(switchMode), .modeWrite,
        .op_mode_select, .nvm_mode_enable, .keyWrite, .nvm_write_key, .statusSecondRead);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic close_out();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // settle a few cycles, then sample mid-cycle
    task automatic idle(input int c);
        repeat (c) @(negedge sys_clk);
    endtask : idle
    // design output picked by code: 0 reset, 1 measurement start, 2 result store
    function automatic logic sig_of(input int w);
        return (w == 0) ? regReset : ((w == 1) ? measStart : resultStore);
    endfunction : sig_of
    // bounded wait for a level on a design output, read at each negedge
    task automatic wait_for(input int w, input logic lvl, input int lim);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (sig_of(w) !== lvl && n < lim);
        if (sig_of(w) !== lvl) begin
            bad_count++;
            close_out();
        end
    endtask : wait_for
    // cycles from a measurement start to the next start or result store
    task automatic gap(input bit toStore, output int g);
        wait_for(1, 1'b1, 5000);
        wait_for(toStore ? 2 : 1, 1'b1, 5000);
        g = n;
    endtask : gap
    task automatic do_reset();
        @(posedge sys_clk);
        #1 rst_n = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        wait_for(0, 1'b0, 20);
    endtask : do_reset
    function automatic logic [2:0] exp_mode(input logic [2:0] c, input logic en);
        return (c == 3'h3 || (c == 3'h1 && !en)) ? 3'h0 : c;
    endfunction : exp_mode
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst_n, soft_reset_bit, ioSupplyLow, nvmReq, nvmWe} = 5'h00;
        {powerdown_pin, supplyOk} = 2'b11;
        {ch1, ch2, ch3, ch4, thrHyst} = '0;
        thrUpper = 16'sh0064;
        thrLower = -16'sh0064;
        filter_cutoff_select = 3'h0;
        void'($urandom(32'h70882a1a));
        s = $urandom_range(2);
        {addr_strap_1, addr_strap_0} = s[1:0];
        do_reset();
        chk("addr", targetAddr, 7'h64 + s[6:0]);
        chk("init", {modeState, intOut, busEnable, switchMode}, 6'h02);
        for (int c = 0; c < 8; c++) begin
            s = $urandom_range(1);
            irmc_host_model_i.set_mode(c[2:0], s[0]);
            idle(3);
            chk("mode", modeState, exp_mode(c[2:0], s[0]));
        end
        // single shot: length, power down, return to standby
        fc = $urandom_range(3);
        @(posedge sys_clk) #1 filter_cutoff_select = fc[2:0];
        irmc_host_model_i.set_mode(3'h2, 1'b0);
        gap(1'b1, n);
        chk("single len", n[15:0], 16'(MB << fc));
        idle(2);
        chk("single off", analogOn, 1'b0);
        irmc_host_model_i.status_done();
        idle(3);
        chk("single back", modeState, 3'h0);
        // continuous modes: update period grows with wait ratio
        for (int k = 0; k < 4; k++) begin
            fc = $urandom_range(2);
            @(posedge sys_clk) #1 filter_cutoff_select = fc[2:0];
            irmc_host_model_i.set_mode(3'h4 + k[2:0], 1'b0);
            d1 = (k == 0) ? 0 : k + 2;
            d2 = (k == 0) ? 0 : 2;
            gap(1'b0, n);
            chk("cont period", n[15:0], 16'((MB << fc) << d1));
            gap(1'b1, n);
            chk("cont meas", n[15:0], 16'((MB << fc) << d2));
        end
        // rewrite mid-measurement aborts with no store
        @(posedge sys_clk) #1 filter_cutoff_select = 3'h3;
        irmc_host_model_i.set_mode(3'h4, 1'b0);
        wait_for(1, 1'b1, 5000);
        irmc_host_model_i.set_mode(3'h0, 1'b0);
        s = 0;
        repeat (40) begin
            @(negedge sys_clk);
            s += (resultStore === 1'b1);
        end
        chk("abort", {s[3:0], modeState}, 7'h00);
        // nvm access: grant, key gate, no measurement
        @(posedge sys_clk) #1 {nvmReq, nvmWe} = 2'b11;
        irmc_host_model_i.set_mode(3'h1, 1'b1);
        idle(3);
        chk("nvm grant", {nvmGrant, nvmWriteGrant}, 2'b10);
        s = $urandom_range(255);
        irmc_host_model_i.write_key((s[7:0] == 8'ha5) ? 8'h00 : s[7:0]);
        idle(2);
        chk("bad key", {nvmWriteGrant, analogOn}, 2'b00);
        irmc_host_model_i.write_key(8'ha5);
        idle(2);
        chk("good key", {nvmWriteGrant, analogOn}, 2'b10);
        irmc_host_model_i.set_mode(3'h0, 1'b0);
        idle(1);
        chk("stby nvm", {nvmGrant, nvmWriteGrant}, 2'b00);
        // four reset sources each clear a running mode
        for (int src = 0; src < 4; src++) begin
            irmc_host_model_i.set_mode(3'h4, 1'b0);
            idle(3);
            @(posedge sys_clk);
            case (src)
                0: #1 powerdown_pin = 1'b0;
                1: #1 ioSupplyLow = 1'b1;
                2: #1 soft_reset_bit = 1'b1;
                default: #1 supplyOk = 1'b0;
            endcase
            wait_for(0, 1'b1, 8);
            @(posedge sys_clk);
            #1 {powerdown_pin, ioSupplyLow, soft_reset_bit, supplyOk} = 4'b1001;
            wait_for(0, 1'b0, 20);
            chk("reset src", {modeState, analogOn}, 4'h0);
        end
        // switch mode: bus off, comparator with hysteresis
        @(posedge sys_clk) #1 {addr_strap_1, addr_strap_0} = 2'b11;
        do_reset();
        chk("switch", {switchMode, busEnable, targetAddr}, 9'h100);
        expInt = 1'b0;
        @(posedge sys_clk) #1 thrHyst = 16'($urandom_range(30));
        repeat (12) begin
            @(posedge sys_clk);
            #1 ch1 = 16'($urandom_range(300));
            ch2 = 16'($urandom_range(300));
            {ch3, ch4} = {16'sh0096, 16'sh0096};
            d1 = int'(ch1) - 150;
            d2 = int'(ch2) - 150;
            if (d1 > 100 || d2 > 100 || d1 < -100 || d2 < -100) begin
                expInt = 1'b1;
            end else if (d1 <= 100 - int'(thrHyst) && d2 <= 100 - int'(thrHyst)
                && d1 >= int'(thrHyst) - 100 && d2 >= int'(thrHyst) - 100) begin
                expInt = 1'b0;
            end
            wait_for(2, 1'b1, 5000);
            wait_for(2, 1'b1, 5000);
            idle(1);
            chk("int out", intOut, expInt);
        end
        close_out();
    end
endmodule : irmc_ctrl_tb
